// ==== design/pdcb_pkg.sv ====
// pdcb_pkg: register map, field layout and reset values of the divider configuration bank
// assumes byte-wide register access with 8-bit addresses
package pdcb_pkg;
    localparam logic [7:0] OUT2_LSDIV_HIGH_ADDR = 8'h22;
    localparam logic [7:0] OUT2_LSDIV_MID_ADDR = 8'h23;
    localparam logic [7:0] OUT2_LSDIV_LOW_ADDR = 8'h24;
    localparam logic [7:0] FEEDBACK_HS_AND_LS_HIGH_ADDR = 8'h28;
    localparam logic [7:0] FEEDBACK_LSDIV_MID_ADDR = 8'h29;
    localparam logic [7:0] FEEDBACK_LSDIV_LOW_ADDR = 8'h2a;
    localparam logic [7:0] IN1_PREDIV_HIGH_ADDR = 8'h2b;
    localparam logic [7:0] IN1_PREDIV_MID_ADDR = 8'h2c;
    localparam logic [7:0] IN1_PREDIV_LOW_ADDR = 8'h2d;
    localparam logic [7:0] IN2_PREDIV_HIGH_ADDR = 8'h2e;
    localparam logic [7:0] IN2_PREDIV_MID_ADDR = 8'h2f;
    localparam logic [7:0] IN2_PREDIV_LOW_ADDR = 8'h30;
    // writable bit masks; reserved bits are zero here
    localparam logic [7:0] NIBBLE_MASK = 8'h0f;
    localparam logic [7:0] HS_AND_NIBBLE_MASK = 8'hef;
    localparam logic [7:0] TRIPLE_MASK = 8'h07;
    localparam logic [7:0] BYTE_MASK = 8'hff;
    // field positions in the feedback high-speed register
    localparam int HS_CODE_LSB = 5;
    localparam logic [3:0] HS_RATIO_BASE = 4'h4;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_OUT2_LOW = 8'h31;
    localparam logic [7:0] RST_FB_HIGH = 8'hc0;
    localparam logic [7:0] RST_FB_LOW = 8'hf9;
    localparam logic [7:0] RST_IN1_LOW = 8'h09;
    localparam int NUM_REGS = 12;
endpackage : pdcb_pkg

// ==== design/pdcb_byte_reg.sv ====
// pdcb_byte_reg: one byte-wide configuration register with a write mask
// assumes write strobe and address decode come from the bank
`timescale 1ns/100ps
`default_nettype none
module pdcb_byte_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hff
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] value
);
    logic [7:0] val_ff;
    logic [7:0] nxt_val;

    // masked bits keep zero so reserved positions never change
    assign nxt_val = wr_en ? (wr_data & WR_MASK) : val_ff;

    // synchronous reset to the register's documented default
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            val_ff <= RESET_VAL & WR_MASK;
        else
            val_ff <= nxt_val;
    end

    assign value = val_ff;
endmodule : pdcb_byte_reg
`default_nettype wire

// ==== design/pdcb_bank.sv ====
// pdcb_bank: divider configuration bank for one pll channel
// assumes a byte-wide management port already decoded from the serial host link
// Summary of operation
// - feedback high-speed ratio equals code plus four
// - feedback low-speed ratio code plus one, even
// - input one prediv ratio equals code plus one
// - input two prediv same encoding, high bits low
// - feedback registers reset to c0, 00, f9
// - output two low byte resets to 31
// - input one prediv resets to ratio ten
// - output two bits 19:16 in low nibble
`timescale 1ns/100ps
`default_nettype none
module pdcb_bank (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic [19:0] out2_lowspeed_div,
    output logic [3:0] feedback_highspeed_div,
    output logic [19:0] feedback_lowspeed_div,
    output logic [18:0] in1_prediv,
    output logic [18:0] in2_prediv
);
    localparam int N = pdcb_pkg::NUM_REGS;
    localparam logic [7:0] ADDRS [N] = '{
        pdcb_pkg::OUT2_LSDIV_HIGH_ADDR, pdcb_pkg::OUT2_LSDIV_MID_ADDR,
        pdcb_pkg::OUT2_LSDIV_LOW_ADDR, pdcb_pkg::FEEDBACK_HS_AND_LS_HIGH_ADDR,
        pdcb_pkg::FEEDBACK_LSDIV_MID_ADDR, pdcb_pkg::FEEDBACK_LSDIV_LOW_ADDR,
        pdcb_pkg::IN1_PREDIV_HIGH_ADDR, pdcb_pkg::IN1_PREDIV_MID_ADDR,
        pdcb_pkg::IN1_PREDIV_LOW_ADDR, pdcb_pkg::IN2_PREDIV_HIGH_ADDR,
        pdcb_pkg::IN2_PREDIV_MID_ADDR, pdcb_pkg::IN2_PREDIV_LOW_ADDR};
    localparam logic [7:0] MASKS [N] = '{
        pdcb_pkg::NIBBLE_MASK, pdcb_pkg::BYTE_MASK, pdcb_pkg::BYTE_MASK,
        pdcb_pkg::HS_AND_NIBBLE_MASK, pdcb_pkg::BYTE_MASK, pdcb_pkg::BYTE_MASK,
        pdcb_pkg::TRIPLE_MASK, pdcb_pkg::BYTE_MASK, pdcb_pkg::BYTE_MASK,
        pdcb_pkg::TRIPLE_MASK, pdcb_pkg::BYTE_MASK, pdcb_pkg::BYTE_MASK};
    localparam logic [7:0] RSTS [N] = '{
        pdcb_pkg::RST_ZERO, pdcb_pkg::RST_ZERO, pdcb_pkg::RST_OUT2_LOW,
        pdcb_pkg::RST_FB_HIGH, pdcb_pkg::RST_ZERO, pdcb_pkg::RST_FB_LOW,
        pdcb_pkg::RST_ZERO, pdcb_pkg::RST_ZERO, pdcb_pkg::RST_IN1_LOW,
        pdcb_pkg::RST_ZERO, pdcb_pkg::RST_ZERO, pdcb_pkg::RST_ZERO};

    // slot of each register in the bank, in address order; the divider
    // assembly below names its bytes through these rather than bare numbers
    localparam int SLOT_OUT2_HIGH = 0;
    localparam int SLOT_OUT2_MID = 1;
    localparam int SLOT_OUT2_LOW = 2;
    localparam int SLOT_FB_HIGH = 3;
    localparam int SLOT_FB_MID = 4;
    localparam int SLOT_FB_LOW = 5;
    localparam int SLOT_IN1_HIGH = 6;
    localparam int SLOT_IN1_MID = 7;
    localparam int SLOT_IN1_LOW = 8;
    localparam int SLOT_IN2_HIGH = 9;
    localparam int SLOT_IN2_MID = 10;
    localparam int SLOT_IN2_LOW = 11;

    // output reset values follow the register defaults, so a divider
    // output and a read of its bytes agree from the first edge after reset
    localparam logic [19:0] OUT2_RST = {pdcb_pkg::RST_ZERO[3:0], pdcb_pkg::RST_ZERO,
        pdcb_pkg::RST_OUT2_LOW};
    localparam logic [19:0] FB_LS_RST = {pdcb_pkg::RST_FB_HIGH[3:0], pdcb_pkg::RST_ZERO,
        pdcb_pkg::RST_FB_LOW};
    localparam logic [18:0] IN1_RST = {pdcb_pkg::RST_ZERO[2:0], pdcb_pkg::RST_ZERO,
        pdcb_pkg::RST_IN1_LOW};
    localparam logic [18:0] IN2_RST = {pdcb_pkg::RST_ZERO[2:0], pdcb_pkg::RST_ZERO,
        pdcb_pkg::RST_ZERO};
    localparam logic [3:0] FB_HS_RST = {1'b0, pdcb_pkg::RST_FB_HIGH[7:pdcb_pkg::HS_CODE_LSB]}
        + pdcb_pkg::HS_RATIO_BASE;

    // bank state, read path and the next values of the registered outputs
    logic [7:0] regv [N];
    logic [N-1:0] hit;
    logic [7:0] rd_term [N];
    logic [7:0] rd_chain [N+1];
    logic [7:0] rd_mux;
    logic [7:0] rdata_ff;
    logic rvalid_ff;
    logic [19:0] out2_ff;
    logic [3:0] fbhs_ff;
    logic [19:0] fbls_ff;
    logic [18:0] in1_ff;
    logic [18:0] in2_ff;
    logic [3:0] nxt_fbhs;
    logic [2:0] fbhs_code;
    logic [19:0] nxt_out2;
    logic [19:0] nxt_fbls;
    logic [18:0] nxt_in1;
    logic [18:0] nxt_in2;
    logic [7:0] nxt_rdata;

    // one masked byte register per address; resets
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_reg
            assign hit[g] = (reg_addr == ADDRS[g]);
            // a slot adds its byte to the read path only when addressed
            assign rd_term[g] = hit[g] ? regv[g] : 8'h00;
            assign rd_chain[g + 1] = rd_chain[g] | rd_term[g];
            pdcb_byte_reg #(
                .RESET_VAL(RSTS[g]),
                .WR_MASK(MASKS[g])
            ) u_reg (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .wr_en(reg_wr & hit[g]),
                .wr_data(reg_wdata),
                .value(regv[g])
            );
        end
    endgenerate

    // read select as an or-chain: addresses are distinct, so at most one
    // slot contributes and an unmapped address falls through to zero;
    // reserved bits are already zero inside each slot
    assign rd_chain[0] = 8'h00;
    assign rd_mux = rd_chain[N];

    // a read answers zero outside its strobe so a stale byte never lingers
    assign nxt_rdata = reg_rd ? rd_mux : 8'h00;

    // each divider value is its bytes high to low; only the writable low
    // bits of a high byte take part, the reserved ones are zero anyway
    assign fbhs_code = regv[SLOT_FB_HIGH][7:pdcb_pkg::HS_CODE_LSB];
    assign nxt_out2 = {regv[SLOT_OUT2_HIGH][3:0], regv[SLOT_OUT2_MID],
        regv[SLOT_OUT2_LOW]};
    assign nxt_fbls = {regv[SLOT_FB_HIGH][3:0], regv[SLOT_FB_MID],
        regv[SLOT_FB_LOW]};
    assign nxt_in1 = {regv[SLOT_IN1_HIGH][2:0], regv[SLOT_IN1_MID],
        regv[SLOT_IN1_LOW]};
    assign nxt_in2 = {regv[SLOT_IN2_HIGH][2:0], regv[SLOT_IN2_MID],
        regv[SLOT_IN2_LOW]};

    // high-speed ratio is code plus four, so 000 gives 4 and 111 gives 11;
    // eleven still fits the four output bits
    assign nxt_fbhs = {1'b0, fbhs_code} + pdcb_pkg::HS_RATIO_BASE;

    // read data registered: answer one cycle after the read strobe
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rdata_ff <= 8'h00;
        else
            rdata_ff <= nxt_rdata;
    end

    // valid marks the one cycle in which the read data stands; the host
    // must take the byte then, nothing holds it longer
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rvalid_ff <= 1'b0;
        else
            rvalid_ff <= reg_rd;
    end

    // output two low-speed code passes through as written; the host keeps it
    // zero or odd, the bank does not police it
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            out2_ff <= OUT2_RST;
        else
            out2_ff <= nxt_out2;
    end

    // feedback high-speed ratio, already decoded to its division value
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            fbhs_ff <= FB_HS_RST;
        else
            fbhs_ff <= nxt_fbhs;
    end

    // feedback low-speed code; the datapath divides by code plus one, so
    // the host must write odd codes for the even ratios the loop can use.
    // an even code is passed on unchanged rather than rounded
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            fbls_ff <= FB_LS_RST;
        else
            fbls_ff <= nxt_fbls;
    end

    // input one pre-divider code; code zero divides by one
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            in1_ff <= IN1_RST;
        else
            in1_ff <= nxt_in1;
    end

    // input two pre-divider code, same encoding as input one; a change
    // takes effect byte by byte, so a multi-byte update passes through
    // intermediate ratios (limitation: no shadow register)
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            in2_ff <= IN2_RST;
        else
            in2_ff <= nxt_in2;
    end

    // every output is the flip-flop itself, no logic after the register
    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign out2_lowspeed_div = out2_ff;
    assign feedback_highspeed_div = fbhs_ff;
    assign feedback_lowspeed_div = fbls_ff;
    assign in1_prediv = in1_ff;
    assign in2_prediv = in2_ff;
endmodule : pdcb_bank
`default_nettype wire

// ==== bench/pdcb_chk.sv ====
// pdcb_chk: port assertions for the divider bank
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module pdcb_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [19:0] out2_lowspeed_div,
    input wire logic [3:0] feedback_highspeed_div,
    input wire logic [19:0] feedback_lowspeed_div,
    input wire logic [18:0] in1_prediv,
    input wire logic [18:0] in2_prediv
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // a write lands in the register, then in the output one edge later
    sequence s_wr(a); reg_wr && reg_addr == a; endsequence
    property p_hs; s_wr(8'h28) |-> ##2 feedback_highspeed_div - 4'h4 == 4'($past(reg_wdata, 2) >> 5);
    endproperty
    a_hs: assert property (p_hs) else $error("hs ratio");
    property p_mid; s_wr(8'h29) |-> ##2 feedback_lowspeed_div[15:8] == $past(reg_wdata, 2); endproperty
    a_mid: assert property (p_mid) else $error("fb mid");
    property p_in1; s_wr(8'h2b) |-> ##2 in1_prediv[18:16] == 3'($past(reg_wdata, 2)); endproperty
    a_in1: assert property (p_in1) else $error("in1 high");
    property p_in2; s_wr(8'h2e) |-> ##2 in2_prediv[18:16] == 3'($past(reg_wdata, 2)); endproperty
    a_in2: assert property (p_in2) else $error("in2 high");
    property p_res; reg_rd && reg_addr == 8'h28 |=> !reg_rdata[4]; endproperty
    a_res: assert property (p_res) else $error("reserved bit");
    property p_unm; reg_rd && reg_addr == 8'h31 |=> reg_rdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_rst; $rose(rst_n) |-> feedback_lowspeed_div == 20'h000f9 && in1_prediv == 19'h9
        && out2_lowspeed_div == 20'h00031 && feedback_highspeed_div == 4'ha;
    endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_stb; !reg_wr [*2] |=> $stable(out2_lowspeed_div); endproperty
    a_stb: assert property (p_stb) else $error("out2 moved");
endmodule : pdcb_chk
bind pdcb_bank pdcb_chk chk (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .out2_lowspeed_div(out2_lowspeed_div),
    .feedback_highspeed_div(feedback_highspeed_div),
    .feedback_lowspeed_div(feedback_lowspeed_div),
    .in1_prediv(in1_prediv),
    .in2_prediv(in2_prediv)
);
`default_nettype wire

// ==== bench/pdcb_host.sv ====
// pdcb_host: management host model issuing byte register cycles
// assumes the bank answers a read one edge after taking it
`timescale 1ns/100ps
`default_nettype none
module pdcb_host (
    input wire logic core_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    // idle data shows the inverse so stale bytes are never mistaken for live ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk);
        {reg_wr, reg_wdata} <= {1'b0, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [8:0] r);
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        // the answer stands one cycle; take it at the edge that closes it
        @(posedge core_clk);
        r = {reg_rvalid, reg_rdata};
    endtask : rd
endmodule : pdcb_host
`default_nettype wire

// ==== bench/pdcb_bank_tb.sv ====
// pdcb_bank_tb: reset, corner and random register traffic against a shadow map
// assumes the host model owns the management port
`timescale 1ns/100ps
`default_nettype none
module pdcb_bank_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, a, d;
    logic [19:0] out2_lowspeed_div, feedback_lowspeed_div;
    logic [3:0] feedback_highspeed_div;
    logic [18:0] in1_prediv, in2_prediv;
    logic [7:0] m [8'h20:8'h31] = '{default: 8'h00};
    logic [8:0] r;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    pdcb_bank uut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .out2_lowspeed_div(out2_lowspeed_div),
        .feedback_highspeed_div(feedback_highspeed_div),
        .feedback_lowspeed_div(feedback_lowspeed_div),
        .in1_prediv(in1_prediv),
        .in2_prediv(in2_prediv)
    );
    pdcb_host host (
        .core_clk(core_clk),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid)
    );
    always #5 core_clk = ~core_clk;
    // a hang counts as a mismatch
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            stop_test();
        end
    end
    function automatic logic [7:0] mask(input logic [7:0] x);
        case (x)
            8'h22: return 8'h0f;
            8'h28: return 8'hef;
            8'h2b, 8'h2e: return 8'h07;
            8'h23, 8'h24, 8'h29, 8'h2a, 8'h2c, 8'h2d, 8'h2f, 8'h30: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction : mask
    // register defaults after reset; every other slot reads zero
    task automatic set_defaults();
        m = '{default: 8'h00};
        {m[8'h24], m[8'h28], m[8'h2a], m[8'h2d]} = 32'h31c0f909;
    endtask : set_defaults
    task automatic chk_rd(input logic [8:0] g, input logic [8:0] e);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_rd
    task automatic chk(input logic [19:0] g, input logic [19:0] e);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // read every address, then compare the assembled divider values
    task automatic sweep();
        for (int i = 8'h20; i <= 8'h31; i++)
        begin
            host.rd(i[7:0], r);
            chk_rd(r, {1'b1, m[i]});
        end
        chk(out2_lowspeed_div, {m[8'h22][3:0], m[8'h23], m[8'h24]});
        chk(20'(feedback_highspeed_div), 20'(m[8'h28][7:5]) + 20'h4);
        chk(feedback_lowspeed_div, {m[8'h28][3:0], m[8'h29], m[8'h2a]});
        chk(20'(in1_prediv), {1'b0, m[8'h2b][2:0], m[8'h2c], m[8'h2d]});
        chk(20'(in2_prediv), {1'b0, m[8'h2e][2:0], m[8'h2f], m[8'h30]});
    endtask : sweep
    task automatic stop_test();
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    initial
    begin
        void'($urandom(32'he700f689));
        set_defaults();
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        sweep();
        // all ones into the part-writable registers: reserved bits stay zero
        host.wr(8'h28, 8'hff);
        host.wr(8'h22, 8'hff);
        host.wr(8'h2b, 8'hff);
        host.wr(8'h2e, 8'hff);
        host.wr(8'h29, 8'h5a);
        {m[8'h22], m[8'h28], m[8'h29], m[8'h2b], m[8'h2e]} = 40'h0fef5a0707;
        sweep();
        repeat (60)
        begin
            a = 8'h20 + 8'($urandom % 18);
            d = 8'($urandom);
            // the host only writes odd low bytes to both low-speed dividers
            d[0] = d[0] | (a == 8'h24) | (a == 8'h2a);
            host.wr(a, d);
            m[a] = d & mask(a);
        end
        sweep();
        // a second reset after traffic brings every register back to default
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        set_defaults();
        sweep();
        stop_test();
    end
endmodule : pdcb_bank_tb
`default_nettype wire
